// file: verilog/fcm_top.sv
// compatibility-mode selection, fifo mode control and polling wrapper
//
// Local design decisions: register access over Wishbone and the register offsets.
`include "fcm_consts.svh"
`timescale 1ns/1ps
module fcm_top
   import fcm_pkg::*;
#(
   parameter int DRIVES = `FCM_NUM_DRIVES,
   parameter int FIFO_DEPTH = 16,
   parameter int POLL_DWELL_CYC = `FCM_POLL_DWELL_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins from outside the clock domain
   input wire logic mode_strap_pin_i,
   input wire logic second_mode_strap_pin_i,
   input wire logic polarity_invert_pin_i,
   input wire logic terminal_count_in_i,
   input wire logic dma_acknowledge_in_n_i,
   // command engine, same clock
   input wire fcm_phase_t phase_i,
   input wire logic cmd_byte_i,
   input wire logic query_done_i,
   input wire logic high_rate_i,
   input wire logic eng_irq_i,
   input wire logic eng_dma_req_i,
   input wire logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level_i,
   // outputs
   output logic density_select_out_o,
   output logic dma_request_out_o,
   output logic dma_request_oe_o,
   output logic irq_o,
   output logic irq_oe_o,
   output logic tc_seen_o,
   output logic fifo_byte_mode_o,
   output logic fifo_burst_o,
   output logic [DRIVES-1:0] drive_select_outputs_o,
   output logic [DRIVES-1:0] poll_pending_o,
   output logic [$clog2(DRIVES)-1:0] poll_head_o
);
   localparam int LW = $clog2(FIFO_DEPTH + 1);

   // ---------------- pin synchronisers ----------------
   fcm_pins_t pins_raw;
   fcm_pins_t pins_s;

   assign pins_raw.mode_strap = mode_strap_pin_i;
   assign pins_raw.second_strap = second_mode_strap_pin_i;
   assign pins_raw.invert = polarity_invert_pin_i;
   assign pins_raw.tc = terminal_count_in_i;
   assign pins_raw.dma_acknowledge_in_n = dma_acknowledge_in_n_i;

   fcm_sync #(
      .W($bits(fcm_pins_t))
   ) u_sync (
      .clk_i(clk_i),
      .d_i(pins_raw),
      .q_o(pins_s)
   );

   // ---------------- strap capture ----------------
   // straps follow the pin while reset is held and freeze at release;
   // the synchroniser output is used, so hold reset at least 3 clocks;
   // the synchroniser itself is never reset, else the straps would read
   // as zero for the whole reset and every part would come up in one mode
   fcm_mode_t mode_r;
   wire fcm_mode_t strap_mode = pins_s.mode_strap ? FCM_MODE_HIGH :
                                pins_s.second_strap ? FCM_MODE_PRIMARY_LOW : FCM_MODE_SECONDARY_LOW;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r <= strap_mode;
      end
   end

   wire mode_primary = (mode_r == FCM_MODE_PRIMARY_LOW);
   wire mode_high = (mode_r == FCM_MODE_HIGH);

   // ---------------- wishbone slave ----------------
   logic ack_r;
   logic [31:0] rdat_r;
   logic [7:0] dor_r;
   logic [7:0] setup_r;

   // ack masks the request for one cycle, so a strobe still high in the ack cycle is not taken again
   wire req = wb_cyc_i && wb_stb_i && !ack_r;
   wire wr = req && wb_we_i && wb_sel_i[0];
   wire sel_dor = (wb_adr_i == `FCM_ADDR_DOR);
   wire sel_setup = (wb_adr_i == `FCM_ADDR_SETUP);
   wire sel_status = (wb_adr_i == `FCM_ADDR_STATUS);

   wire dma_gate_bit = dor_r[`FCM_DOR_GATE_BIT];
   wire [1:0] dor_sel = dor_r[`FCM_DOR_SEL_MSB:`FCM_DOR_SEL_LSB];
   wire [3:0] dor_en = dor_r[`FCM_DOR_EN_MSB:`FCM_DOR_EN_LSB];
   wire fifo_en = setup_r[`FCM_SET_FIFO_EN_BIT];
   wire poll_en = !setup_r[`FCM_SET_POLL_DIS_BIT];
   wire [3:0] fifo_thr = setup_r[`FCM_SET_THR_MSB:`FCM_SET_THR_LSB];

   logic [DRIVES-1:0] poll_ready;
   logic [DRIVES-1:0] poll_pend;
   logic poll_irq;
   logic poll_active;
   logic byte_mode_r;

   // status is a live snapshot; reading it changes nothing
   logic [31:0] status_word;
   always_comb begin
      status_word = '0;
      status_word[`FCM_ST_MODE_MSB:`FCM_ST_MODE_LSB] = mode_r;
      status_word[`FCM_ST_BYTE_BIT] = byte_mode_r;
      status_word[`FCM_ST_IRQ_BIT] = poll_irq;
      status_word[`FCM_ST_RDY_MSB:`FCM_ST_RDY_LSB] = 4'(poll_ready);
      status_word[`FCM_ST_PEND_MSB:`FCM_ST_PEND_LSB] = 4'(poll_pend);
      status_word[`FCM_ST_POLL_BIT] = poll_active;
   end

   // unmapped offsets read zero and still acknowledge
   wire [31:0] rd_mux = sel_dor ? {24'h00_0000, dor_r} :
                        sel_setup ? {24'h00_0000, setup_r} :
                        sel_status ? status_word : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdat_r <= '0;
      end else begin
         ack_r <= req;
         if (req && !wb_we_i) rdat_r <= rd_mux;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // out of reset the fifo is off and polling is on
         dor_r <= `FCM_DOR_RESET;
         setup_r <= `FCM_SET_RESET;
      end else begin
         // status writes fall through: acknowledged and dropped
         if (wr && sel_dor) dor_r <= wb_dat_i[7:0];
         if (wr && sel_setup) setup_r <= wb_dat_i[7:0];
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // ---------------- polling ----------------
   wire waiting = !phase_i.cmd && !phase_i.exec && !phase_i.result;
   wire seeking = phase_i.seek && !phase_i.implied;
   // the command byte also holds run low so the abort cannot restart the loop
   wire poll_run = poll_en && !cmd_byte_i && (waiting || seeking);

   // queries pop pending entries even while the loop is stopped

   fcm_poll #(
      .DRIVES(DRIVES),
      .DWELL_CYC(POLL_DWELL_CYC)
   ) u_poll (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(poll_run),
      .abort_i(cmd_byte_i),
      .query_i(query_done_i),
      .ready_o(poll_ready),
      .pending_o(poll_pend),
      .head_o(poll_head_o),
      .irq_o(poll_irq),
      .active_o(poll_active)
   );

   assign poll_pending_o = poll_pend;

   // drive selects follow only the digital output register; polling never
   // touches them, it only walks the saved ready bits
   logic [DRIVES-1:0] dsel_r;
   logic [DRIVES-1:0] dsel_dec;
   always_comb begin
      dsel_dec = '0;
      for (int i = 0; i < DRIVES; i++) begin
         dsel_dec[i] = dor_en[i] && (dor_sel == 2'(i));
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dsel_r <= '0;
      end else begin
         dsel_r <= dsel_dec;
      end
   end
   assign drive_select_outputs_o = dsel_r;

   // ---------------- fifo mode ----------------
   // byte mode whenever fifo is off or outside execution phase
   wire byte_mode = !fifo_en || !phase_i.exec;
   // threshold field counts from zero, so level thr+1 starts a burst
   wire [LW-1:0] thr_lvl = LW'(fifo_thr) + LW'(1);
   logic burst_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         byte_mode_r <= 1'b1;
         burst_r <= 1'b0;
      end else begin
         byte_mode_r <= byte_mode;
         // queued data goes out as a burst from threshold down to empty
         if (byte_mode) burst_r <= 1'b0;
         else if (fifo_level_i >= thr_lvl) burst_r <= 1'b1;
         else if (fifo_level_i == '0) burst_r <= 1'b0;
      end
   end

   assign fifo_byte_mode_o = byte_mode_r;
   assign fifo_burst_o = burst_r;

   // ---------------- density select ----------------
   logic density_select_out_r;
   wire density_select_out_active = mode_high ? high_rate_i : !high_rate_i;

   always_ff @(posedge clk_i) begin
      // invert pin flips either polarity after the mode choice
      if (rst_i) begin
         density_select_out_r <= 1'b0;
      end else begin
         density_select_out_r <= density_select_out_active ^ pins_s.invert;
      end
   end
   assign density_select_out_o = density_select_out_r;

   // ---------------- terminal count ----------------
   // primary low mode takes tc active low; the other two take it active high
   wire tc_level = mode_primary ? !pins_s.tc : pins_s.tc;
   wire tc_qual = tc_level && !pins_s.dma_acknowledge_in_n;
   // edge detect: a count held for several clocks flags only once
   logic tc_q_r;
   logic tc_seen_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tc_q_r <= 1'b0;
         tc_seen_r <= 1'b0;
      end else begin
         tc_q_r <= tc_qual;
         tc_seen_r <= tc_qual && !tc_q_r;
      end
   end
   assign tc_seen_o = tc_seen_r;

   // ---------------- request and interrupt drivers ----------------
   // gate bit only counts outside the primary low mode
   // enables stay combinational so a gate write acts in the ack cycle
   wire drive_en = mode_primary ? 1'b1 : dma_gate_bit;
   wire drq_src = byte_mode ? eng_dma_req_i : (eng_dma_req_i && burst_r);
   logic drq_r;
   logic irq_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drq_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         drq_r <= drq_src;
         irq_r <= eng_irq_i || poll_irq;
      end
   end

   assign dma_request_out_o = drq_r;
   assign irq_o = irq_r;
   assign dma_request_oe_o = drive_en;
   assign irq_oe_o = drive_en;

endmodule : fcm_top

// file: verilog/fcm_consts.svh
// constants for the floppy compatibility-mode and drive-polling block
`ifndef FCM_CONSTS_SVH
`define FCM_CONSTS_SVH

// register byte offsets (word aligned)
`define FCM_ADDR_DOR 4'h0
`define FCM_ADDR_SETUP 4'h4
`define FCM_ADDR_STATUS 4'h8

// digital output register fields
`define FCM_DOR_SEL_LSB 0
`define FCM_DOR_SEL_MSB 1
`define FCM_DOR_GATE_BIT 3
`define FCM_DOR_EN_LSB 4
`define FCM_DOR_EN_MSB 7
`define FCM_DOR_RESET 8'h00

// setup-options register fields
`define FCM_SET_FIFO_EN_BIT 0
`define FCM_SET_POLL_DIS_BIT 1
`define FCM_SET_THR_LSB 4
`define FCM_SET_THR_MSB 7
`define FCM_SET_RESET 8'h00

// status register fields
`define FCM_ST_MODE_LSB 0
`define FCM_ST_MODE_MSB 1
`define FCM_ST_BYTE_BIT 2
`define FCM_ST_IRQ_BIT 3
`define FCM_ST_RDY_LSB 4
`define FCM_ST_RDY_MSB 7
`define FCM_ST_PEND_LSB 8
`define FCM_ST_PEND_MSB 11
`define FCM_ST_POLL_BIT 12

// polling dwell per simulated drive
`define FCM_POLL_DWELL_US 62
`define FCM_CLK_MHZ 25
`define FCM_POLL_DWELL_CYC (`FCM_POLL_DWELL_US * `FCM_CLK_MHZ)

`define FCM_NUM_DRIVES 4

`endif

// file: verilog/fcm_pkg.sv
// types shared by the compatibility-mode and polling block
package fcm_pkg;

   typedef enum logic [1:0] {
      FCM_MODE_PRIMARY_LOW = 2'h0,
      FCM_MODE_SECONDARY_LOW = 2'h1,
      FCM_MODE_HIGH = 2'h2
   } fcm_mode_t;

   typedef enum logic [1:0] {
      FCM_POLL_IDLE = 2'b00,
      FCM_POLL_DWELL = 2'b01,
      FCM_POLL_STEP = 2'b11
   } fcm_poll_state_t;

   // controller phase as reported by the command engine
   typedef struct packed {
      logic cmd;
      logic exec;
      logic result;
      logic seek;
      logic implied;
   } fcm_phase_t;

   // external pins that need synchronising
   typedef struct packed {
      logic mode_strap;
      logic second_strap;
      logic invert;
      logic tc;
      logic dma_acknowledge_in_n;
   } fcm_pins_t;

endpackage : fcm_pkg

// file: verilog/fcm_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module fcm_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // no reset: strap pins must reach the capture flop while reset is held
   always_ff @(posedge clk_i) begin
      meta_r <= d_i;
      q_r <= meta_r;
   end

   assign q_o = q_r;
endmodule : fcm_sync

// file: verilog/fcm_poll.sv
// simulated legacy drive polling with queued status per drive
`include "fcm_consts.svh"
`timescale 1ns/1ps
module fcm_poll
   import fcm_pkg::*;
#(
   parameter int DRIVES = `FCM_NUM_DRIVES,
   parameter int DWELL_CYC = `FCM_POLL_DWELL_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic abort_i,
   input wire logic query_i,
   output logic [DRIVES-1:0] ready_o,
   output logic [DRIVES-1:0] pending_o,
   output logic [$clog2(DRIVES)-1:0] head_o,
   output logic irq_o,
   output logic active_o
);
   localparam int DW = $clog2(DWELL_CYC + 1);
   localparam int IW = $clog2(DRIVES);
   localparam logic [DW-1:0] DWELL_LAST = DW'(DWELL_CYC - 1);
   localparam logic [IW-1:0] IDX_LAST = IW'(DRIVES - 1);

   fcm_poll_state_t state_r, state_nxt;
   logic [DW-1:0] cnt_r;
   logic [IW-1:0] idx_r;
   logic [DRIVES-1:0] ready_r;
   logic [DRIVES-1:0] pend_r;
   logic irq_r;

   wire dwell_done = (cnt_r == DWELL_LAST);
   // ready input is taken as permanently true, so only a stored not-ready changes
   wire changes = (state_r == FCM_POLL_STEP) && !ready_r[idx_r];
   wire [DRIVES-1:0] set_mask = changes ? (DRIVES'(1) << idx_r) : '0;
   wire [DRIVES-1:0] low_pend = pend_r & (~pend_r + DRIVES'(1));
   wire [DRIVES-1:0] clr_mask = query_i ? low_pend : '0;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         FCM_POLL_IDLE: begin
            if (run_i) state_nxt = FCM_POLL_DWELL;
         end
         FCM_POLL_DWELL: begin
            if (!run_i) state_nxt = FCM_POLL_IDLE;
            else if (dwell_done) state_nxt = FCM_POLL_STEP;
         end
         FCM_POLL_STEP: begin
            state_nxt = run_i ? FCM_POLL_DWELL : FCM_POLL_IDLE;
         end
         default: state_nxt = FCM_POLL_IDLE;
      endcase
      if (abort_i) state_nxt = FCM_POLL_IDLE;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= FCM_POLL_IDLE;
         cnt_r <= '0;
         idx_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= (state_r == FCM_POLL_DWELL && !dwell_done) ? cnt_r + DW'(1) : '0;
         if (state_r == FCM_POLL_STEP) begin
            idx_r <= (idx_r == IDX_LAST) ? '0 : idx_r + IW'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_r <= '0;
         pend_r <= '0;
         irq_r <= 1'b0;
      end else begin
         ready_r <= ready_r | set_mask;
         pend_r <= (pend_r & ~clr_mask) | set_mask;
         // set wins over clear; line drops after the first query only
         if (changes) irq_r <= 1'b1;
         else if (query_i) irq_r <= 1'b0;
      end
   end

   always_comb begin
      head_o = '0;
      for (int i = DRIVES - 1; i >= 0; i--) begin
         if (pend_r[i]) head_o = IW'(i);
      end
   end

   assign ready_o = ready_r;
   assign pending_o = pend_r;
   assign irq_o = irq_r;
   assign active_o = (state_r != FCM_POLL_IDLE);
endmodule : fcm_poll

// file: testbench/fcm_top_assertions.sv
// port-level checks for the compatibility and polling block
`timescale 1ns/1ps
module fcm_top_chk
   import fcm_pkg::*;
#(
   parameter int DRIVES = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic dma_acknowledge_in_n_i,
   input wire fcm_phase_t phase_i,
   input wire logic query_done_i,
   input wire logic eng_irq_i,
   input wire logic dma_request_oe_o,
   input wire logic irq_oe_o,
   input wire logic irq_o,
   input wire logic tc_seen_o,
   input wire logic fifo_byte_mode_o,
   input wire logic [DRIVES-1:0] drive_select_outputs_o,
   input wire logic [DRIVES-1:0] poll_pending_o,
   input wire logic [$clog2(DRIVES)-1:0] poll_head_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // all four queued, so no set can collide with the pop
   sequence s_query_all;
      query_done_i && !eng_irq_i && (&poll_pending_o) ##1 !eng_irq_i;
   endsequence
   sequence s_byte_phase;
      (phase_i.cmd || phase_i.result) [*3];
   endsequence
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_oe_pair: assert property (dma_request_oe_o == irq_oe_o)
      else $error("request and interrupt enables differ");
   a_oe_on_write: assert property ($changed(dma_request_oe_o) |-> wb_ack_o)
      else $error("request enable moved without a register write");
   a_dsel_write: assert property ($changed(drive_select_outputs_o)
      |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2))
      else $error("drive selects moved without a register write");
   a_tc_pulse: assert property (tc_seen_o |=> !tc_seen_o)
      else $error("terminal count flag not a pulse");
   a_tc_needs_ack: assert property (dma_acknowledge_in_n_i [*5] |-> !tc_seen_o)
      else $error("terminal count seen without acknowledge");
   a_irq_first_query: assert property (s_query_all |=> !irq_o)
      else $error("interrupt held after first query");
   a_pop_lowest: assert property (query_done_i && |poll_pending_o |=>
      (poll_pending_o & $past(poll_pending_o)) == ($past(poll_pending_o) & ($past(poll_pending_o) - 1'h1)))
      else $error("query did not pop the lowest entry");
   a_head_lowest: assert property (|poll_pending_o |-> poll_pending_o[poll_head_o]
      && ((poll_pending_o & ((1 << poll_head_o) - 1)) == 0))
      else $error("head is not the lowest pending drive");
   a_byte_cmd: assert property (s_byte_phase |-> fifo_byte_mode_o)
      else $error("not byte mode in command or result");
endmodule : fcm_top_chk

bind fcm_top fcm_top_chk #(.DRIVES(DRIVES)) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .dma_acknowledge_in_n_i, .phase_i, .query_done_i, .eng_irq_i, .dma_request_oe_o,
   .irq_oe_o, .irq_o, .tc_seen_o, .fifo_byte_mode_o, .drive_select_outputs_o, .poll_pending_o,
   .poll_head_o);

// file: testbench/fcm_dma_model.sv
// dma controller stand-in: acknowledges requests, drives terminal count
`timescale 1ns/1ps
module fcm_dma_model (
   input wire logic clk_i,
   input wire logic drq_i,
   input wire logic drq_oe_i,
   input wire logic tc_high_i,
   input wire logic slow_i,
   input wire logic end_i,
   output logic dma_acknowledge_in_n_o = 1'h1,
   output logic tc_o = 1'h0
);
   logic seen_r = 1'h0;
   // a floating request line is never answered
   always @(posedge clk_i) begin
      seen_r <= drq_i && drq_oe_i;
      dma_acknowledge_in_n_o <= !(drq_i && drq_oe_i && (!slow_i || seen_r));
      tc_o <= tc_high_i ? end_i : !end_i;
   end
endmodule : fcm_dma_model

// file: testbench/fcm_top_tb_top.sv
// self-checking bench for the compatibility and polling block
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin err_count++; \
   $display("wrong value %s exp %0h got %0h", n, e, a); end end
module fcm_top_tb_top;
   import fcm_pkg::*;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic we = 1'h0, cyc = 1'h0, stb = 1'h0, ack;
   logic ms = 1'h0, ss = 1'h1, inv = 1'h0, tcp, dackn, cbyte = 1'h0, qd = 1'h0;
   logic hr = 1'h0, edrq = 1'h0, tch = 1'h0, endt = 1'h0, slow = 1'h0;
   fcm_phase_t ph = 5'h00;
   logic [4:0] lvl = 5'h00;
   logic dsel, dma_request_out, drq_oe, irq, irq_oe, tcs, bm, bur;
   logic [3:0] ds, pp;
   logic [1:0] head;
   int err_count = 0;
   int n_checks = 0;
   always #20 clk_i = ~clk_i;
   fcm_top #(.POLL_DWELL_CYC(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
      .mode_strap_pin_i(ms), .second_mode_strap_pin_i(ss), .polarity_invert_pin_i(inv),
      .terminal_count_in_i(tcp), .dma_acknowledge_in_n_i(dackn), .phase_i(ph), .cmd_byte_i(cbyte),
      .query_done_i(qd), .high_rate_i(hr), .eng_irq_i(1'h0), .eng_dma_req_i(edrq), .fifo_level_i(lvl),
      .density_select_out_o(dsel), .dma_request_out_o(dma_request_out), .dma_request_oe_o(drq_oe), .irq_o(irq),
      .irq_oe_o(irq_oe), .tc_seen_o(tcs), .fifo_byte_mode_o(bm), .fifo_burst_o(bur),
      .drive_select_outputs_o(ds), .poll_pending_o(pp), .poll_head_o(head));
   fcm_dma_model u_dma (.clk_i(clk_i), .drq_i(dma_request_out), .drq_oe_i(drq_oe), .tc_high_i(tch), .slow_i(slow),
      .end_i(endt), .dma_acknowledge_in_n_o(dackn), .tc_o(tcp));
   task automatic finish_test();
      if (err_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wt
   task automatic wb(input logic [3:0] a, input logic [7:0] d, input logic w, output logic [31:0] q);
      @(posedge clk_i);
      adr <= a;
      wdat <= {24'h00_0000, d};
      we <= w;
      cyc <= 1'h1;
      stb <= 1'h1;
      // waits for ack; if ack never comes, only the watchdog ends this wait
      do begin
         @(posedge clk_i);
      end while (ack !== 1'h1);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
   endtask : wb
   task automatic rst_mode(input logic m, input logic s);
      ms <= m;
      ss <= s;
      rst_i <= 1'h1;
      wt(20);
      rst_i <= 1'h0;
   endtask : rst_mode
   task automatic tc_try(input logic on, output logic [3:0] hits);
      edrq <= on;
      wt(6);
      endt <= 1'h1;
      wt(1);
      endt <= 1'h0;
      hits = 4'h0;
      repeat (8) begin
         @(posedge clk_i);
         hits = hits + tcs;
      end
      edrq <= 1'h0;
   endtask : tc_try
   task automatic t_mode(input logic m, input logic s, input logic [1:0] md);
      logic [31:0] q;
      logic [3:0] hits;
      tch <= (md != 2'h0);
      slow <= (md == 2'h1);
      rst_mode(m, s);
      @(posedge clk_i);
      `CHK("byte mode", 1'h1, bm)
      wb(4'h8, 8'h00, 1'h0, q);
      `CHK("mode", md, q[1:0])
      `CHK("gate off oe", md == 2'h0, drq_oe)
      wb(4'hc, 8'h00, 1'h0, q);
      `CHK("unmapped", 32'h0000_0000, q)
      wb(4'h0, 8'h18, 1'h1, q);
      hr <= 1'h1;
      wt(4);
      `CHK("gate on oe", 1'h1, irq_oe)
      `CHK("drive select", 4'h1, ds)
      `CHK("density", md == 2'h2, dsel)
      inv <= 1'h1;
      wt(4);
      `CHK("density inverted", md != 2'h2, dsel)
      inv <= 1'h0;
      tc_try(1'h1, hits);
      `CHK("tc acked", 4'h1, hits)
      tc_try(1'h0, hits);
      `CHK("tc unacked", 4'h0, hits)
   endtask : t_mode
   task automatic t_poll();
      logic [31:0] q;
      logic [3:0] prev;
      int k;
      rst_mode(1'h0, 1'h1);
      wb(4'h8, 8'h00, 1'h0, q);
      `CHK("ready after reset", 4'h0, q[7:4])
      prev = 4'h0;
      k = 0;
      repeat (40) begin
         @(posedge clk_i);
         if (pp !== prev) begin
            `CHK("poll order", 4'h1 << k, pp & ~prev)
            k++;
            prev = pp;
         end
         `CHK("drive selects", 4'h0, ds)
      end
      `CHK("pending all", 4'hf, pp)
      `CHK("poll irq", 1'h1, irq)
      wb(4'h8, 8'h00, 1'h0, q);
      `CHK("ready saved", 4'hf, q[7:4])
      for (k = 0; k < 4; k++) begin
         qd <= 1'h1;
         wt(1);
         qd <= 1'h0;
         wt(3);
         `CHK("irq after query", 1'h0, irq)
      end
      `CHK("pending cleared", 4'h0, pp)
   endtask : t_poll
   task automatic t_stop();
      logic [31:0] q;
      rst_mode(1'h0, 1'h1);
      wt(3);
      cbyte <= 1'h1;
      ph <= 5'h10;
      wt(1);
      cbyte <= 1'h0;
      wt(40);
      `CHK("poll in command", 4'h0, pp)
      ph <= 5'h0b;
      wt(40);
      `CHK("poll implied seek", 4'h0, pp)
      ph <= 5'h02;
      wt(40);
      `CHK("poll in seek", 4'hf, pp)
      ph <= 5'h00;
      rst_mode(1'h0, 1'h1);
      wb(4'h4, 8'h02, 1'h1, q);
      wt(40);
      `CHK("poll disabled", 4'h0, pp)
   endtask : t_stop
   task automatic t_fifo();
      logic [31:0] q;
      rst_mode(1'h0, 1'h1);
      wb(4'h4, 8'h13, 1'h1, q);
      ph <= 5'h10;
      wt(3);
      `CHK("byte in command", 1'h1, bm)
      ph <= 5'h04;
      wt(3);
      `CHK("byte in result", 1'h1, bm)
      ph <= 5'h08;
      edrq <= 1'h1;
      lvl <= 5'h01;
      wt(3);
      `CHK("exec byte mode", 1'h0, bm)
      `CHK("below threshold", 1'h0, dma_request_out)
      lvl <= 5'h02;
      wt(3);
      `CHK("burst on", 1'h1, bur)
      `CHK("burst request", 1'h1, dma_request_out)
      lvl <= 5'h00;
      wt(3);
      `CHK("burst off", 1'h0, bur)
      edrq <= 1'h0;
      ph <= 5'h00;
   endtask : t_fifo
   initial begin
      @(posedge clk_i);
      t_mode(1'h1, 1'h0, 2'h2);
      t_mode(1'h0, 1'h1, 2'h0);
      t_mode(1'h0, 1'h0, 2'h1);
      t_poll();
      t_stop();
      t_fifo();
      finish_test();
   end
   // tests need about 530 cycles; wide margin
   initial begin
      wt(20000);
      err_count++;
      finish_test();
   end
endmodule : fcm_top_tb_top
